// File: far_end_scheduler.sv
// Far-end scheduler model: turns received status codes into credit grants
`timescale 1ns/1ps
`default_nettype none

module far_end_scheduler #(
	parameter int MAX_BURST1 = 8,
	parameter int MAX_BURST2 = 4
) (
	input  wire logic                              status_clk,
	input  wire logic                              rst,
	input  wire rx_flow_status_pkg::status_code_t  status_code,
	input  wire logic                              status_strobe,
	output logic [3:0][7:0]                        grant
);
	logic [2:0] slot_q;

	always_ff @(posedge status_clk or posedge rst) begin
		if (rst) begin
			slot_q <= 3'h0;
			grant  <= '0;
		end else if (status_strobe) begin
			if (status_code == rx_flow_status_pkg::CODE_FRAMING) begin
				slot_q <= 3'h0;
			end else begin
				slot_q <= slot_q + 3'h1;
				case (status_code)
					rx_flow_status_pkg::CODE_SATISFIED: grant[slot_q[1:0]] <= 8'h00;
					rx_flow_status_pkg::CODE_HUNGRY: grant[slot_q[1:0]] <= 8'(MAX_BURST2);
					default: grant[slot_q[1:0]] <= 8'(MAX_BURST1);
				endcase
			end
		end
	end
endmodule

`default_nettype wire

// File: rx_flow_status.sv
// Receiver flow-control status generation with status-link clock crossing
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Writes to unprovisioned ports are stored but never read back.
// - With external status selected, port status comes from the hold memory.
// - Calculated status compares port fill against almost-empty and almost-full thresholds.
// - Shared-buffer mode calculates every port from the single shared fill level.
// - Any clock-crossing or receive buffer overflow forces all ports to satisfied.
// - Status goes out as 2-bit codes on status clock; 11 only frames.
// - Code 10 means satisfied; far end grants no new credits.
// - Code 01 means hungry; far end grants MaxBurst2 credits.
// - Code 00 means starving; far end grants MaxBurst1 credits.
// - Single clock mode builds receive buffers in one clock domain only.
// - Multiple clock mode runs protocol logic and buffer writes on system clock.
// - Multiple clock mode gives each receive buffer its own read clock.
// - Slow read clocks fill buffers; device then applies backpressure on status link.
// - Shared-buffer variations instantiate only the port 0 buffer.
// - Status clock comes from interface clock or status processor, by width.
// - 32-bit shared-buffer variations tie system clock to interface clock.
// - 32-bit quarter-rate mode runs data path and buffer writes on interface clock.
// - Asynchronous global reset is synchronised into every clock domain.
// - Global reset clears buffered data and state bits; status word and code reset to framing code 11.
// - External write port is 8-bit address, 2-bit status, valid.
// - Individual-buffers mode forces the status-source override low.
module rx_flow_status (
	input  wire logic                               clk,
	input  wire logic                               rst,
	input  wire logic                               status_clk,
	input  wire rx_flow_status_pkg::buf_mode_t      buf_mode,
	input  wire logic                               status_source_override,
	input  wire rx_flow_status_pkg::ext_status_wr_t ext_status_wr,
	input  wire rx_flow_status_pkg::thresholds_t    thresholds,
	input  wire rx_flow_status_pkg::fill_levels_t   fill_level,
	input  wire logic                               data_clock_crossing_buffer_overflow,
	input  wire logic                               rx_buffer_overflow,
	output logic                                    force_satisfied,
	output rx_flow_status_pkg::status_code_t        status_code,
	output logic                                    status_strobe
);

	function automatic rx_flow_status_pkg::status_code_t calc_status(
		input logic [rx_flow_status_pkg::FILL_W-1:0] fill,
		input rx_flow_status_pkg::thresholds_t       th
	);
		if (fill >= th.almost_full_threshold) begin
			calc_status = rx_flow_status_pkg::CODE_SATISFIED;
		end else if (fill <= th.almost_empty_threshold) begin
			calc_status = rx_flow_status_pkg::CODE_STARVING;
		end else begin
			calc_status = rx_flow_status_pkg::CODE_HUNGRY;
		end
	endfunction

	// Reset synchronisers, one per domain; assert at once, release on the clock
	logic [1:0] sys_rst_pipe;
	logic [1:0] link_rst_pipe;
	logic       sys_rst;
	logic       link_rst;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sys_rst_pipe <= rx_flow_status_pkg::RST_PIPE_INIT;
		end else begin
			sys_rst_pipe <= {sys_rst_pipe[0], 1'b0};
		end
	end

	always_ff @(posedge status_clk or posedge rst) begin
		if (rst) begin
			link_rst_pipe <= rx_flow_status_pkg::RST_PIPE_INIT;
		end else begin
			link_rst_pipe <= {link_rst_pipe[0], 1'b0};
		end
	end

	assign sys_rst  = sys_rst_pipe[1];
	assign link_rst = link_rst_pipe[1];

	// System clock domain: hold memory, calculator and calendar walk
	rx_flow_status_pkg::sys_state_t sys_q;
	rx_flow_status_pkg::sys_state_t sys_d;
	rx_flow_status_pkg::link_state_t link_q;
	rx_flow_status_pkg::link_state_t link_d;

	logic                                       override_eff;
	logic                                       ovf_now;
	logic                                       ack_stable;
	logic                                       send;
	logic [rx_flow_status_pkg::FILL_W-1:0]      slot_fill;
	rx_flow_status_pkg::status_code_t           calc_code;
	rx_flow_status_pkg::status_code_t           hold_code;
	rx_flow_status_pkg::status_code_t           port_code;
	logic [rx_flow_status_pkg::PORT_W-1:0]      slot_port;

	always_comb begin
		sys_d = sys_q;
		// Individual buffers send the calculated value unless an overflow forces satisfied
		override_eff = (buf_mode == rx_flow_status_pkg::MODE_SHARED) && status_source_override;
		ovf_now = data_clock_crossing_buffer_overflow || rx_buffer_overflow;
		// Two bits only, so the framing slot never addresses an unprovisioned word
		slot_port = {{(rx_flow_status_pkg::PORT_W - 2){1'b0}},
			sys_q.slot[1:0]};
		// Shared mode has only the port 0 buffer, so its level stands for all
		if (buf_mode == rx_flow_status_pkg::MODE_SHARED) begin
			slot_fill = fill_level[0];
		end else begin
			slot_fill = fill_level[sys_q.slot[1:0]];
		end
		calc_code = calc_status(slot_fill, thresholds);
		// Only provisioned addresses are ever read from the hold memory
		hold_code = sys_q.mem[slot_port];
		if (ovf_now) begin
			port_code = rx_flow_status_pkg::CODE_SATISFIED;
		end else if (override_eff) begin
			port_code = hold_code;
		end else begin
			port_code = calc_code;
		end

		// Any address, any order; no sequencing is assumed
		if (ext_status_wr.valid) begin
			sys_d.mem[ext_status_wr.addr] = ext_status_wr.status;
		end

		sys_d.ack_sync = {sys_q.ack_sync[1:0], link_q.ack};
		ack_stable = (sys_q.ack_sync[1] == sys_q.ack_sync[2]);
		send = ack_stable && (sys_q.ack_sync[2] == sys_q.req);
		if (send) begin
			if (sys_q.slot == rx_flow_status_pkg::SLOT_FRAMING) begin
				sys_d.word = rx_flow_status_pkg::CODE_FRAMING;
				sys_d.slot = rx_flow_status_pkg::SLOT_RESET;
			end else begin
				sys_d.word = port_code;
				sys_d.slot = sys_q.slot + 3'h1;
			end
			sys_d.req = ~sys_q.req;
		end
		sys_d.forced = ovf_now;
	end

	// Protocol logic on the system clock in every clock mode
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sys_q.mem      <= {rx_flow_status_pkg::NUM_ADDR{rx_flow_status_pkg::MEM_RESET}};
			sys_q.slot     <= rx_flow_status_pkg::SLOT_RESET;
			sys_q.word     <= rx_flow_status_pkg::CODE_RESET;
			sys_q.req      <= rx_flow_status_pkg::TOGGLE_RESET;
			sys_q.ack_sync <= rx_flow_status_pkg::SYNC_RESET;
			sys_q.forced   <= 1'b0;
		end else begin
			sys_q <= sys_d;
		end
	end

	// Fill levels arrive already on the system clock; buffer read clocks stay
	// outside this block, so single and multiple clock modes look the same here

	// Status clock domain; the word stays stable while the toggle crosses
	always_comb begin
		link_d = link_q;
		link_d.strobe = 1'b0;
		link_d.req_sync = {link_q.req_sync[1:0], sys_q.req};
		if ((link_q.req_sync[1] == link_q.req_sync[2])
			&& (link_q.req_sync[2] != link_q.ack)) begin
			link_d.code = sys_q.word;
			link_d.strobe = 1'b1;
			link_d.ack = link_q.req_sync[2];
		end
	end

	always_ff @(posedge status_clk or posedge link_rst) begin
		if (link_rst) begin
			link_q.req_sync <= rx_flow_status_pkg::SYNC_RESET;
			link_q.ack      <= rx_flow_status_pkg::TOGGLE_RESET;
			link_q.code     <= rx_flow_status_pkg::CODE_RESET;
			link_q.strobe   <= 1'b0;
		end else begin
			link_q <= link_d;
		end
	end

	assign force_satisfied = sys_q.forced;
	assign status_code     = link_q.code;
	assign status_strobe   = link_q.strobe;

	property p_framing_only_at_wrap;
		@(posedge clk) disable iff (sys_rst)
		($changed(sys_q.req) && sys_q.word == rx_flow_status_pkg::CODE_FRAMING)
			|-> (sys_q.slot == rx_flow_status_pkg::SLOT_RESET);
	endproperty
	a_framing_only_at_wrap: assert property (p_framing_only_at_wrap)
		else $error("Framing code sent outside the frame wrap");

	property p_port_never_framing;
		@(posedge clk) disable iff (sys_rst)
		($changed(sys_q.req) && sys_q.slot != rx_flow_status_pkg::SLOT_RESET)
			|-> (sys_q.word != rx_flow_status_pkg::CODE_FRAMING);
	endproperty
	a_port_never_framing: assert property (p_port_never_framing)
		else $error("Port slot carried the framing code");

	property p_overflow_forces_satisfied;
		@(posedge clk) disable iff (sys_rst)
		(send && ovf_now && sys_q.slot != rx_flow_status_pkg::SLOT_FRAMING)
			|=> (sys_q.word == rx_flow_status_pkg::CODE_SATISFIED && sys_q.forced);
	endproperty
	a_overflow_forces_satisfied: assert property (p_overflow_forces_satisfied)
		else $error("Overflow did not force satisfied status");

	property p_write_stored;
		@(posedge clk) disable iff (sys_rst)
		ext_status_wr.valid
			|=> (sys_q.mem[$past(ext_status_wr.addr)] == $past(ext_status_wr.status));
	endproperty
	a_write_stored: assert property (p_write_stored)
		else $error("External status write not stored");

	property p_individual_uses_calc;
		@(posedge clk) disable iff (sys_rst)
		(send && !ovf_now && buf_mode == rx_flow_status_pkg::MODE_INDIVIDUAL
			&& sys_q.slot != rx_flow_status_pkg::SLOT_FRAMING)
			|=> (sys_q.word == $past(calc_code));
	endproperty
	a_individual_uses_calc: assert property (p_individual_uses_calc)
		else $error("Individual mode sent a value other than the calculated one");

	property p_override_uses_hold;
		@(posedge clk) disable iff (sys_rst)
		(send && !ovf_now && override_eff
			&& sys_q.slot != rx_flow_status_pkg::SLOT_FRAMING)
			|=> (sys_q.word == $past(sys_q.mem[slot_port]));
	endproperty
	a_override_uses_hold: assert property (p_override_uses_hold)
		else $error("External status not taken from hold memory");

	property p_shared_uses_port0;
		@(posedge clk) disable iff (sys_rst)
		(buf_mode == rx_flow_status_pkg::MODE_SHARED)
			|-> (calc_code == calc_status(fill_level[0], thresholds));
	endproperty
	a_shared_uses_port0: assert property (p_shared_uses_port0)
		else $error("Shared mode status not based on the shared level");

	property p_code_changes_with_strobe;
		@(posedge status_clk) disable iff (link_rst)
		$changed(status_code) |-> status_strobe ##1 !status_strobe;
	endproperty
	a_code_changes_with_strobe: assert property (p_code_changes_with_strobe)
		else $error("Status code changed without a one-cycle strobe");

	property p_satisfied_at_full;
		@(posedge clk) disable iff (sys_rst)
		(slot_fill >= thresholds.almost_full_threshold)
			|-> (calc_code == rx_flow_status_pkg::CODE_SATISFIED);
	endproperty
	a_satisfied_at_full: assert property (p_satisfied_at_full)
		else $error("Almost-full level not reported satisfied");

	property p_starving_at_empty;
		@(posedge clk) disable iff (sys_rst)
		(slot_fill < thresholds.almost_full_threshold && slot_fill <= thresholds.almost_empty_threshold)
			|-> (calc_code == rx_flow_status_pkg::CODE_STARVING);
	endproperty
	a_starving_at_empty: assert property (p_starving_at_empty)
		else $error("Almost-empty level not reported starving");

	property p_hungry_between;
		@(posedge clk) disable iff (sys_rst)
		(slot_fill < thresholds.almost_full_threshold && slot_fill > thresholds.almost_empty_threshold)
			|-> (calc_code == rx_flow_status_pkg::CODE_HUNGRY);
	endproperty
	a_hungry_between: assert property (p_hungry_between)
		else $error("Midpoint level not reported hungry");

	property p_calc_individual_port;
		@(posedge clk) disable iff (sys_rst)
		(buf_mode == rx_flow_status_pkg::MODE_INDIVIDUAL)
			|-> (calc_code == calc_status(fill_level[sys_q.slot[1:0]], thresholds));
	endproperty
	a_calc_individual_port: assert property (p_calc_individual_port)
		else $error("Individual mode status not based on the slot's own level");

	property p_individual_no_override;
		@(posedge clk) disable iff (sys_rst)
		(buf_mode == rx_flow_status_pkg::MODE_INDIVIDUAL)
			|-> !override_eff;
	endproperty
	a_individual_no_override: assert property (p_individual_no_override)
		else $error("Override effective in individual mode");

	property p_force_follows_overflow;
		@(posedge clk) disable iff (sys_rst)
		1'b1
			|=> (force_satisfied == $past(ovf_now));
	endproperty
	a_force_follows_overflow: assert property (p_force_follows_overflow)
		else $error("Force flag does not follow the overflow inputs");

	property p_slot_in_range;
		@(posedge clk) disable iff (sys_rst)
		1'b1
			|-> (sys_q.slot <= rx_flow_status_pkg::SLOT_FRAMING);
	endproperty
	a_slot_in_range: assert property (p_slot_in_range)
		else $error("Calendar slot out of range");

	property p_hold_read_provisioned;
		@(posedge clk) disable iff (sys_rst)
		1'b1
			|-> (slot_port < rx_flow_status_pkg::PORT_W'(rx_flow_status_pkg::NUM_PORTS));
	endproperty
	a_hold_read_provisioned: assert property (p_hold_read_provisioned)
		else $error("Hold memory read at an unprovisioned address");

	// Word must not move while the toggle is still crossing
	property p_word_held;
		@(posedge clk) disable iff (sys_rst)
		!send
			|=> ($stable(sys_q.word) && $stable(sys_q.req));
	endproperty
	a_word_held: assert property (p_word_held)
		else $error("Status word changed during a crossing");

	property p_req_toggles_on_send;
		@(posedge clk) disable iff (sys_rst)
		send
			|=> (sys_q.req != $past(sys_q.req));
	endproperty
	a_req_toggles_on_send: assert property (p_req_toggles_on_send)
		else $error("Request toggle missing on send");

	property p_slot_advances;
		@(posedge clk) disable iff (sys_rst)
		(send && sys_q.slot != rx_flow_status_pkg::SLOT_FRAMING)
			|=> (sys_q.slot == $past(sys_q.slot) + 3'h1);
	endproperty
	a_slot_advances: assert property (p_slot_advances)
		else $error("Calendar slot did not advance");

	property p_framing_after_last;
		@(posedge clk) disable iff (sys_rst)
		(send && sys_q.slot == rx_flow_status_pkg::SLOT_FRAMING)
			|=> (sys_q.word == rx_flow_status_pkg::CODE_FRAMING && sys_q.slot == rx_flow_status_pkg::SLOT_RESET);
	endproperty
	a_framing_after_last: assert property (p_framing_after_last)
		else $error("Framing word missing after the last port");

	property p_strobe_single;
		@(posedge status_clk) disable iff (link_rst)
		status_strobe
			|=> !status_strobe;
	endproperty
	a_strobe_single: assert property (p_strobe_single)
		else $error("Status strobe longer than one cycle");

	property p_strobe_carries_word;
		@(posedge status_clk) disable iff (link_rst)
		status_strobe
			|-> (status_code == sys_q.word);
	endproperty
	a_strobe_carries_word: assert property (p_strobe_carries_word)
		else $error("Delivered code differs from the launched word");

	property p_ack_follows_req;
		@(posedge status_clk) disable iff (link_rst)
		status_strobe
			|-> (link_q.ack == link_q.req_sync[2]);
	endproperty
	a_ack_follows_req: assert property (p_ack_follows_req)
		else $error("Acknowledge toggle not returned with the strobe");

endmodule

`default_nettype wire

// File: rx_flow_status_pkg.sv
// Constants, codes and carrier types for receiver flow-control status
package rx_flow_status_pkg;

	localparam int PORT_W    = 8;
	localparam int NUM_ADDR  = 256;
	localparam int NUM_PORTS = 4;
	localparam int FILL_W    = 8;
	localparam int SLOT_W    = 3;
	localparam int SYNC_N    = 3;

	localparam logic [SLOT_W-1:0] SLOT_RESET    = 3'h0;
	localparam logic [SLOT_W-1:0] SLOT_FRAMING  = 3'h4;
	localparam logic              TOGGLE_RESET  = 1'h0;
	localparam logic [SYNC_N-1:0] SYNC_RESET    = 3'h0;
	localparam logic [1:0]        RST_PIPE_INIT = 2'h3;

	typedef enum logic [1:0] {
		CODE_STARVING  = 2'b00,
		CODE_HUNGRY    = 2'b01,
		CODE_SATISFIED = 2'b10,
		CODE_FRAMING   = 2'b11
	} status_code_t;

	localparam status_code_t MEM_RESET  = CODE_STARVING;
	localparam status_code_t CODE_RESET = CODE_FRAMING;

	typedef enum logic {
		MODE_INDIVIDUAL = 1'b0,
		MODE_SHARED     = 1'b1
	} buf_mode_t;

	typedef struct packed {
		logic              valid;
		logic [PORT_W-1:0] addr;
		status_code_t      status;
	} ext_status_wr_t;

	typedef struct packed {
		logic [FILL_W-1:0] almost_empty_threshold;
		logic [FILL_W-1:0] almost_full_threshold;
	} thresholds_t;

	typedef logic [NUM_PORTS-1:0][FILL_W-1:0] fill_levels_t;

	typedef struct packed {
		status_code_t [NUM_ADDR-1:0] mem;
		logic [SLOT_W-1:0]           slot;
		status_code_t                word;
		logic                        req;
		logic [SYNC_N-1:0]           ack_sync;
		logic                        forced;
	} sys_state_t;

	typedef struct packed {
		logic [SYNC_N-1:0] req_sync;
		logic              ack;
		status_code_t      code;
		logic              strobe;
	} link_state_t;

endpackage

// File: tb_top.sv
// Self-checking bench for receiver flow-control status generation
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin n_errors++; \
	$display("mismatch at %0t: %s", $time, m); end end

module tb_top;
	localparam int BURST1 = 8;
	localparam int BURST2 = 4;
	logic clk = 0, status_clk = 0, rst = 1, ovr = 0, ovf_a = 0, ovf_b = 0;
	rx_flow_status_pkg::buf_mode_t buf_mode = rx_flow_status_pkg::MODE_INDIVIDUAL;
	rx_flow_status_pkg::ext_status_wr_t wr = '0;
	rx_flow_status_pkg::thresholds_t th = '0;
	rx_flow_status_pkg::fill_levels_t fl = '0;
	logic force_satisfied, status_strobe;
	rx_flow_status_pkg::status_code_t status_code;
	logic [3:0][7:0] grant;
	rx_flow_status_pkg::status_code_t exp_q[$];
	rx_flow_status_pkg::status_code_t mem[4];
	int n_errors = 0, checks = 0;

	always #25 clk = ~clk;
	always #6 status_clk = ~status_clk;

	rx_flow_status rx_flow_status_i (.clk(clk), .rst(rst), .status_clk(status_clk),
		.buf_mode(buf_mode), .status_source_override(ovr), .ext_status_wr(wr),
		.thresholds(th), .fill_level(fl), .data_clock_crossing_buffer_overflow(ovf_a),
		.rx_buffer_overflow(ovf_b), .force_satisfied(force_satisfied),
		.status_code(status_code), .status_strobe(status_strobe));
	far_end_scheduler #(.MAX_BURST1(BURST1), .MAX_BURST2(BURST2)) far_end_scheduler_i (
		.status_clk(status_clk), .rst(rst),
		.status_code(status_code), .status_strobe(status_strobe), .grant(grant));

	// Pops one note per delivered word; unexpected words outside a scene are ignored
	always @(posedge status_clk) begin
		if (status_strobe === 1'b1 && exp_q.size() > 0) begin
			`CHK(status_code, exp_q.pop_front(), "status code")
		end
	end

	function automatic rx_flow_status_pkg::status_code_t calc(logic [7:0] f);
		if (f >= th.almost_full_threshold) return rx_flow_status_pkg::CODE_SATISFIED;
		if (f <= th.almost_empty_threshold) return rx_flow_status_pkg::CODE_STARVING;
		return rx_flow_status_pkg::CODE_HUNGRY;
	endfunction

	// Credits the far end should hold for a port after a given code
	function automatic logic [7:0] credit(rx_flow_status_pkg::status_code_t c);
		if (c == rx_flow_status_pkg::CODE_SATISFIED) return 8'h00;
		if (c == rx_flow_status_pkg::CODE_HUNGRY) return 8'(BURST2);
		return 8'(BURST1);
	endfunction

	task automatic scene(input rx_flow_status_pkg::buf_mode_t m, input logic o, a, b,
			input logic [7:0] ae, af, input rx_flow_status_pkg::fill_levels_t f);
		rx_flow_status_pkg::status_code_t e[4];
		@(posedge clk);
		buf_mode <= m; ovr <= o; ovf_a <= a; ovf_b <= b; fl <= f;
		th <= '{almost_empty_threshold: ae, almost_full_threshold: af};
		@(posedge clk);
		@(negedge clk);
		`CHK(force_satisfied, a | b, "force flag")
		repeat (300) begin
			@(posedge status_clk);
			if (status_strobe === 1'b1 && status_code === rx_flow_status_pkg::CODE_FRAMING) break;
		end
		@(negedge status_clk);
		for (int p = 0; p < 4; p++) begin
			if (a | b) e[p] = rx_flow_status_pkg::CODE_SATISFIED;
			else if (m == rx_flow_status_pkg::MODE_SHARED && o) e[p] = mem[p];
			else e[p] = calc(m == rx_flow_status_pkg::MODE_SHARED ? f[0] : f[p]);
			exp_q.push_back(e[p]);
		end
		exp_q.push_back(rx_flow_status_pkg::CODE_FRAMING);
		repeat (400) if (exp_q.size() > 0) @(posedge status_clk);
		`CHK(exp_q.size(), 0, "frame not delivered")
		@(negedge status_clk);
		for (int p = 0; p < 4; p++) begin
			`CHK(grant[p], credit(e[p]), "grant")
		end
	endtask

	task automatic write(input logic [7:0] adr, input rx_flow_status_pkg::status_code_t s);
		@(posedge clk);
		wr <= '{valid: 1'b1, addr: adr, status: s};
		if (adr < 8'h04) mem[adr[1:0]] = s;
	endtask

	task automatic results;
		$display("comparisons %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#500000;
		n_errors++;
		results();
	end

	initial begin
		logic [7:0] ae, af;
		void'($urandom(32'hbc6a));
		foreach (mem[i]) mem[i] = rx_flow_status_pkg::MEM_RESET;
		repeat (2) @(posedge clk);
		// Clocks run from time zero, so release is safe; no aligner unlock here
		rst <= 1'b0;
		scene(rx_flow_status_pkg::MODE_INDIVIDUAL, 1, 0, 0, 8'h14, 8'hc8,
			{8'hc8, 8'hc7, 8'h15, 8'h14});
		for (int i = 0; i < 3; i++) begin
			ae = 8'($urandom_range(60, 10));
			af = ae + 8'($urandom_range(100, 20));
			scene(rx_flow_status_pkg::MODE_INDIVIDUAL, 0, 0, 0, ae, af, 32'($urandom));
		end
		scene(rx_flow_status_pkg::MODE_SHARED, 0, 0, 0, 8'h10, 8'h80,
			{8'h00, 8'hff, 8'h00, 8'h80});
		scene(rx_flow_status_pkg::MODE_SHARED, 0, 0, 0, 8'h10, 8'h80,
			{8'hff, 8'h00, 8'hff, 8'h10});
		write(8'h03, rx_flow_status_pkg::CODE_HUNGRY);
		write(8'h01, rx_flow_status_pkg::CODE_SATISFIED);
		write(8'h00, rx_flow_status_pkg::CODE_HUNGRY);
		write(8'h02, rx_flow_status_pkg::CODE_SATISFIED);
		write(8'h00, rx_flow_status_pkg::CODE_SATISFIED);
		for (int i = 4; i < 8; i++) write(8'(i), rx_flow_status_pkg::CODE_STARVING);
		write(8'hff, rx_flow_status_pkg::CODE_HUNGRY);
		@(posedge clk);
		wr.valid <= 1'b0;
		scene(rx_flow_status_pkg::MODE_SHARED, 1, 0, 0, 8'h10, 8'h80, '0);
		scene(rx_flow_status_pkg::MODE_SHARED, 1, 1, 0, 8'h10, 8'h80, '0);
		scene(rx_flow_status_pkg::MODE_INDIVIDUAL, 0, 0, 1, 8'h10, 8'h80, '0);
		@(posedge clk);
		rst <= 1'b1;
		#1;
		`CHK(status_code, rx_flow_status_pkg::CODE_FRAMING, "code in reset")
		`CHK(force_satisfied, 1'b0, "force in reset")
		foreach (mem[i]) mem[i] = rx_flow_status_pkg::MEM_RESET;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		scene(rx_flow_status_pkg::MODE_SHARED, 1, 0, 0, 8'h10, 8'h80, {4{8'hff}});
		results();
	end
endmodule

`default_nettype wire
